// [hdl/tvrc_timer.sv]
// Timer value/reload/compare register slice with APB slave and low-half flags.
// Assumes APB on clock; cap_pin is asynchronous and synchronised here.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module tvrc_timer
  import tvrc_pkg::*;
#(
  parameter bit SINGLE_PIN = 1'b0
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer pins
  input  wire logic              cap_pin,
  output logic                   secondary_output_enable,
  output logic                   low_half_irq,
  output logic                   split_width_mode
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [1:0] lanes(input logic [5:0] idx, input logic [5:0] full,
                                       input logic [5:0] hi, input logic wr,
                                       input logic split);
    logic lo_en;
    logic hi_en;
    lo_en = wr && (idx == full);
    hi_en = wr && (((idx == full) && !split) || (idx == hi));
    return {hi_en, lo_en};
  endfunction

  function automatic logic [31:0] view16(input logic [15:0] v, input logic split);
    return {16'h0000, (split ? HI_HIDDEN : v[15:8]), v[7:0]};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  tvrc_apb_t   state_q, state_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        lien_q, lien_d;
  logic        oe2_q, oe2_d;
  logic        lovf_q, lovf_d;
  logic        lcmp_q, lcmp_d;
  logic        split_q, split_d;
  logic        run_q, run_d;
  logic        irq_q, irq_d;
  logic        cap_s1_q, cap_s2_q, cap_s3_q;
  logic [15:0] cnt_q, rld_q, cap_q;
  logic [15:0] cnt_nx;
  logic        cnt_ld, cap_ld;
  logic        lo_ovf, lo_match, cap_edge;
  logic [5:0]  idx;
  logic        hit, wr;
  logic [1:0]  cnt_we, rld_we, cap_we;
  logic [15:0] wd16;
  logic [7:0]  ctrl_rd, cfg_rd;

  assign idx = paddr[7:2];
  assign hit = (paddr[1:0] == 2'b00) &&
               ((idx >= IDX_CTRL) && (idx <= IDX_CAP_HI));
  assign wr  = (state_q == TVRC_ACCESS) && psel && penable && pwrite && !pslverr_q;

  // Byte registers carry their byte in bits 7:0, steered to the upper lane
  assign wd16   = (idx >= IDX_CNT_HI) ? {pwdata[7:0], pwdata[7:0]} : pwdata[15:0];
  assign cnt_we = lanes(idx, IDX_CNT, IDX_CNT_HI, wr, split_q);
  assign rld_we = lanes(idx, IDX_RLD, IDX_RLD_HI, wr, split_q);
  assign cap_we = lanes(idx, IDX_CAP, IDX_CAP_HI, wr, split_q);

  // ==========================================================================
  // Value registers
  // ==========================================================================
  tvrc_byte_reg u_cnt (
    .clock  (clock),
    .rst    (rst),
    .we_lo  (cnt_we[0]),
    .we_hi  (cnt_we[1]),
    .wdata  (wd16),
    .ld     (cnt_ld),
    .ld_val (cnt_nx),
    .q      (cnt_q)
  );

  tvrc_byte_reg u_rld (
    .clock  (clock),
    .rst    (rst),
    .we_lo  (rld_we[0]),
    .we_hi  (rld_we[1]),
    .wdata  (wd16),
    .ld     (1'b0),
    .ld_val (VAL_RESET),
    .q      (rld_q)
  );

  tvrc_byte_reg u_cap (
    .clock  (clock),
    .rst    (rst),
    .we_lo  (cap_we[0]),
    .we_hi  (cap_we[1]),
    .wdata  (wd16),
    .ld     (cap_ld),
    .ld_val (cnt_q),
    .q      (cap_q)
  );

  // ==========================================================================
  // Counting
  // ==========================================================================
  assign cap_edge = cap_s2_q && !cap_s3_q;

  always_comb begin
    lo_ovf   = split_q && run_q && (cnt_q[7:0] == BYTE_MAX);
    lo_match = split_q && run_q && (cnt_q[7:0] == cap_q[7:0]);
    cnt_ld   = run_q;
    cnt_nx   = cnt_q;
    if (split_q) begin
      cnt_nx[7:0]  = lo_ovf ? rld_q[7:0] : cnt_q[7:0] + 8'h01;
      cnt_nx[15:8] = (cnt_q[15:8] == BYTE_MAX) ? rld_q[15:8] : cnt_q[15:8] + 8'h01;
    end else begin
      cnt_nx = (cnt_q == WORD_MAX) ? rld_q : cnt_q + 16'h0001;
    end
    cap_ld = cap_edge && !split_q;
  end

  // ==========================================================================
  // Control, flags and bus
  // ==========================================================================
  always_comb begin
    ctrl_rd = CTRL_RESET;
    ctrl_rd[CTL_LIEN_BIT] = lien_q;
    ctrl_rd[CTL_OE2_BIT]  = oe2_q;
    ctrl_rd[CTL_LOVF_BIT] = lovf_q;
    ctrl_rd[CTL_LCMP_BIT] = lcmp_q;
    cfg_rd = CFG_RESET;
    cfg_rd[CFG_SPLIT_BIT] = split_q;
    cfg_rd[CFG_RUN_BIT]   = run_q;
  end

  always_comb begin
    state_d   = state_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    lien_d    = lien_q;
    oe2_d     = oe2_q;
    split_d   = split_q;
    run_d     = run_q;
    lovf_d    = lovf_q;
    lcmp_d    = lcmp_q;
    case (state_q)
      TVRC_IDLE: begin
        if (psel && !penable) begin
          state_d   = TVRC_ACCESS;
          pready_d  = 1'b1;
          pslverr_d = !hit;
          prdata_d  = RD_ZERO;
          if (hit && !pwrite) begin
            case (idx)
              IDX_CTRL:   prdata_d = {24'h000000, ctrl_rd};
              IDX_CNT:    prdata_d = view16(cnt_q, split_q);
              IDX_RLD:    prdata_d = view16(rld_q, split_q);
              IDX_CAP:    prdata_d = view16(cap_q, split_q);
              IDX_CFG:    prdata_d = {24'h000000, cfg_rd};
              IDX_CNT_HI: prdata_d = {24'h000000, cnt_q[15:8]};
              IDX_RLD_HI: prdata_d = {24'h000000, rld_q[15:8]};
              IDX_CAP_HI: prdata_d = {24'h000000, cap_q[15:8]};
              default:    prdata_d = RD_ZERO;
            endcase
          end
        end
      end
      TVRC_ACCESS: begin
        state_d = TVRC_IDLE;
      end
      default: begin
        state_d = TVRC_IDLE;
      end
    endcase
    if (wr && (idx == IDX_CTRL)) begin
      lien_d = pwdata[CTL_LIEN_BIT];
      oe2_d  = SINGLE_PIN ? 1'b0 : pwdata[CTL_OE2_BIT];
      lovf_d = lovf_q && pwdata[CTL_LOVF_BIT];
      lcmp_d = lcmp_q && pwdata[CTL_LCMP_BIT];
    end
    if (wr && (idx == IDX_CFG)) begin
      split_d = pwdata[CFG_SPLIT_BIT];
      run_d   = pwdata[CFG_RUN_BIT];
    end
    if (lo_ovf) begin
      lovf_d = 1'b1;
    end
    if (lo_match) begin
      lcmp_d = 1'b1;
    end
    irq_d = lien_d && (lovf_d || lcmp_d);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q   <= TVRC_IDLE;
      prdata_q  <= RD_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      lien_q    <= 1'b0;
      oe2_q     <= 1'b0;
      lovf_q    <= 1'b0;
      lcmp_q    <= 1'b0;
      split_q   <= 1'b0;
      run_q     <= 1'b0;
      irq_q     <= 1'b0;
      cap_s1_q  <= 1'b0;
      cap_s2_q  <= 1'b0;
      cap_s3_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      lien_q    <= lien_d;
      oe2_q     <= oe2_d;
      lovf_q    <= lovf_d;
      lcmp_q    <= lcmp_d;
      split_q   <= split_d;
      run_q     <= run_d;
      irq_q     <= irq_d;
      cap_s1_q  <= cap_pin;
      cap_s2_q  <= cap_s1_q;
      cap_s3_q  <= cap_s2_q;
    end
  end

  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign secondary_output_enable = oe2_q;
  assign low_half_irq            = irq_q;
  assign split_width_mode        = split_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_irq_tracks_flags: assert property (
    (lien_q && (lovf_q || lcmp_q)) |-> low_half_irq)
    else $error("Low-half request missing while enabled and flagged");

  a_irq_needs_enable: assert property (
    low_half_irq |-> (lien_q && (lovf_q || lcmp_q)))
    else $error("Low-half request high without enable and flag");

  a_oe2_absent: assert property (
    SINGLE_PIN |-> !secondary_output_enable)
    else $error("Secondary output enable set on single-pin variant");

  a_split_cnt_hides: assert property (
    (psel && !penable && !pwrite && (paddr == {IDX_CNT, 2'b00}) && split_q)
      |=> (prdata[15:8] == HI_HIDDEN) && pready)
    else $error("Count high byte visible in split mode");

  a_split_rld_block: assert property (
    (wr && (idx == IDX_RLD) && split_q) |=> (rld_q[15:8] == $past(rld_q[15:8])))
    else $error("Reload high byte written through 16-bit view in split mode");

  a_full_rld_write: assert property (
    (wr && (idx == IDX_RLD) && !split_q) |=> (rld_q == $past(pwdata[15:0])))
    else $error("Reload register did not take all sixteen bits");

  a_hi_shared_view: assert property (
    (psel && !penable && !pwrite && (paddr == {IDX_RLD_HI, 2'b00}))
      |=> (prdata[7:0] == $past(rld_q[15:8])))
    else $error("High-byte reload view differs from reload upper byte");

  a_low_ovf_sets: assert property (
    (split_q && run_q && (cnt_q[7:0] == BYTE_MAX)) |=> lovf_q && (low_half_irq == lien_q))
    else $error("Low overflow flag not set on low-half wrap");

  a_hi_byte_write: assert property (
    (wr && (idx == IDX_CNT_HI) && !run_q) |=> (cnt_q[15:8] == $past(pwdata[7:0])))
    else $error("Count high-byte register did not take the written byte");

  a_low_cmp_only_split: assert property (
    (!split_q && !lcmp_q && !(wr && (idx == IDX_CFG))) |=> !lcmp_q)
    else $error("Low compare flag set outside split mode");

  a_capture_loads: assert property (
    (cap_edge && !split_q && !cap_we[0] && !cap_we[1]) |=> (cap_q == $past(cnt_q)))
    else $error("Capture did not load the count");

  a_wrap_reloads: assert property (
    (!split_q && run_q && (cnt_q == WORD_MAX) && !cnt_we[0] && !cnt_we[1])
      |=> (cnt_q == $past(rld_q)))
    else $error("16-bit counter did not reload on overflow");

  c_split_overflow: cover property (split_q && lo_ovf ##1 low_half_irq);
  c_capture_16: cover property (cap_ld);
  c_hi_write: cover property (wr && (idx == IDX_CNT_HI) && split_q);

endmodule

`default_nettype wire

// [hdl/tvrc_pkg.sv]
// Constants, register map and types of the timer value/reload/compare slice.
// Assumes an APB master with 32-bit data on the same clock as the timer.
//
// Notes on behaviour
// - Control bit 7 is the local enable of the low-half overflow and compare flag sources.
// - On single-output-pin variants the secondary output enable at bit 6 does not exist.
// - The count, reload and capture/compare registers clear to zero on every reset.
// - The count register holds the current count, all sixteen bits read/write in 16-bit mode.
// - In split mode the count register reads zero in its high byte and ignores high-byte writes.
// - A separate high-byte count register reaches the upper half in split mode.
// - The reload register holds the reload value, all sixteen bits read/write in 16-bit mode.
// - In split mode the reload register reads zero in its high byte and drops high-byte writes.
// - A separate high-byte reload register reaches the upper reload byte in split mode.
// - The capture/compare register supplies the match value and is loaded with captured counts.
// - In split mode the capture/compare register reads zero high and blocks high-byte writes.
// - A separate high-byte capture/compare register gives upper-byte access in split mode.
// - Width mode bit zero (reset) selects one 16-bit counter and one selects two 8-bit halves.
// - In split mode only, the low-half overflow flag sets whenever the low 8-bit timer overflows.
// - In split mode only, a low-byte match sets the low compare flag; no low-half capture.

package tvrc_pkg;

  // ==========================================================================
  // Bus
  // ==========================================================================
  localparam int unsigned APB_AW = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL   = 6'h0B;
  localparam logic [5:0] IDX_CNT    = 6'h0C;
  localparam logic [5:0] IDX_RLD    = 6'h0D;
  localparam logic [5:0] IDX_CAP    = 6'h0E;
  localparam logic [5:0] IDX_CFG    = 6'h0F;
  localparam logic [5:0] IDX_CNT_HI = 6'h10;
  localparam logic [5:0] IDX_RLD_HI = 6'h11;
  localparam logic [5:0] IDX_CAP_HI = 6'h12;

  // ==========================================================================
  // Fields
  // ==========================================================================
  localparam int unsigned CTL_LCMP_BIT  = 0;
  localparam int unsigned CTL_LOVF_BIT  = 2;
  localparam int unsigned CTL_OE2_BIT   = 6;
  localparam int unsigned CTL_LIEN_BIT  = 7;
  localparam int unsigned CFG_SPLIT_BIT = 3;
  localparam int unsigned CFG_RUN_BIT   = 4;

  // ==========================================================================
  // Reset and fixed values
  // ==========================================================================
  localparam logic [15:0] VAL_RESET  = 16'h0000;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [7:0]  HI_HIDDEN  = 8'h00;
  localparam logic [7:0]  BYTE_MAX   = 8'hFF;
  localparam logic [15:0] WORD_MAX   = 16'hFFFF;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [0:0] {
    TVRC_IDLE   = 1'b0,
    TVRC_ACCESS = 1'b1
  } tvrc_apb_t;

endpackage

// [hdl/tvrc_byte_reg.sv]
// 16-bit register with separate byte-lane writes and a hardware load.
// Assumes the caller decides lane enables; a software lane write wins.
`timescale 1ns/1ns
`default_nettype none

module tvrc_byte_reg
  import tvrc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Software lanes
  input  wire logic        we_lo,
  input  wire logic        we_hi,
  input  wire logic [15:0] wdata,
  // Hardware load
  input  wire logic        ld,
  input  wire logic [15:0] ld_val,
  // Stored value
  output logic      [15:0] q
);

  logic [15:0] q_d;

  always_comb begin
    q_d = q;
    if (ld) begin
      q_d = ld_val;
    end
    if (we_lo) begin
      q_d[7:0] = wdata[7:0];
    end
    if (we_hi) begin
      q_d[15:8] = wdata[15:8];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= VAL_RESET;
    end else begin
      q <= q_d;
    end
  end

endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the timer value/reload/compare register slice.
// Assumes the APB slave answers within twenty cycles; integer model.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import tvrc_pkg::*;

  // ==========================================================================
  // Signals and model
  // ==========================================================================
  logic        clock;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        cap_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        soe;
  logic        soe_single;
  logic        irq;
  logic        split;
  logic [31:0] rd;
  logic        er;
  logic [5:0]  k;
  int          m_val[3];
  int          m_ctrl;
  int          m_cfg;
  int          num_errors;
  int          checks;
  int          seed;

  tvrc_timer #(.SINGLE_PIN(1'b0)) tvrc_timer_inst (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_pin(cap_pin), .secondary_output_enable(soe),
    .low_half_irq(irq), .split_width_mode(split));

  // Single-pin variant on the same bus, watched for its output enable only
  tvrc_timer #(.SINGLE_PIN(1'b1)) tvrc_timer_single_inst (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .cap_pin(cap_pin), .secondary_output_enable(soe_single),
    .low_half_irq(), .split_width_mode());

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic tally_and_finish;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bus write mirrored into the model
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    chk({31'h0, er}, 32'h0);
    if (idx == IDX_CTRL) begin
      m_ctrl = (wd & 32'hC0) | (m_ctrl & wd & 32'h05);
    end else if (idx == IDX_CFG) begin
      m_cfg = wd & 32'h18;
    end else if (idx <= IDX_CAP) begin
      m_val[idx - IDX_CNT] = m_cfg[3] ? ((m_val[idx - IDX_CNT] & 32'hFF00) | (wd & 32'hFF))
                                      : (wd & 32'hFFFF);
    end else begin
      m_val[idx - IDX_CNT_HI] = (m_val[idx - IDX_CNT_HI] & 32'hFF) | ((wd & 32'hFF) << 8);
    end
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] mask);
    logic [31:0] e;
    apb(1'b0, idx, 32'h0);
    if (idx == IDX_CTRL) begin
      e = m_ctrl;
    end else if (idx == IDX_CFG) begin
      e = m_cfg;
    end else if (idx <= IDX_CAP) begin
      e = m_cfg[3] ? (m_val[idx - IDX_CNT] & 32'hFF) : m_val[idx - IDX_CNT];
    end else begin
      e = m_val[idx - IDX_CNT_HI] >> 8;
    end
    chk(rd & mask, e & mask);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    seed = 32'h4c7d;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cap_pin = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 11; i <= 18; i++) rdchk(6'(i), 32'hFFFF_FFFF);
    chk({29'h0, soe, irq, split}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      k = IDX_CNT + 6'(i % 3);
      wr(k, $random(seed));
      rdchk(k, 32'hFFFF_FFFF);
      rdchk(k + 6'h4, 32'hFFFF_FFFF);
    end
    wr(IDX_CFG, 32'h08);
    @(posedge clock);
    chk({31'h0, split}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      k = IDX_CNT + 6'(i % 3);
      wr(k, $random(seed));
      rdchk(k, 32'hFFFF_FFFF);
      wr(k + 6'h4, $random(seed));
      rdchk(k + 6'h4, 32'hFFFF_FFFF);
    end
    wr(IDX_CFG, 32'h00);
    for (int i = 0; i < 3; i++) rdchk(IDX_CNT + 6'(i), 32'hFFFF_FFFF);
    wr(IDX_CTRL, 32'h40);
    @(posedge clock);
    chk({30'h0, soe, soe_single}, 32'h2);
    // Capture of a stopped count
    wr(IDX_CNT, $random(seed));
    cap_pin <= 1'b1;
    repeat (8) @(posedge clock);
    cap_pin <= 1'b0;
    m_val[2] = m_val[0];
    rdchk(IDX_CAP, 32'hFFFF_FFFF);
    apb(1'b0, 6'h20, 32'h0);
    chk(rd | {31'h0, er}, 32'h1);
    // Full-width run through a low-byte wrap must leave the low flags clear
    wr(IDX_CTRL, 32'h80);
    wr(IDX_CAP, 32'h0);
    wr(IDX_RLD, 32'h0);
    wr(IDX_CNT, 32'hFFFE);
    wr(IDX_CFG, 32'h10);
    wr(IDX_CFG, 32'h00);
    rdchk(IDX_CTRL, 32'hC5);
    irq_chk(1'b0);
    // Split run: low half passes its compare byte and overflows
    wr(IDX_CFG, 32'h08);
    wr(IDX_CNT, 32'hFE);
    wr(IDX_CAP, 32'hFF);
    wr(IDX_CFG, 32'h18);
    wr(IDX_CFG, 32'h08);
    m_ctrl = 32'h85;
    rdchk(IDX_CTRL, 32'hC5);
    irq_chk(1'b1);
    wr(IDX_CTRL, 32'h05);
    irq_chk(1'b0);
    wr(IDX_CTRL, 32'h85);
    irq_chk(1'b1);
    wr(IDX_CTRL, 32'h80);
    irq_chk(1'b0);
    // Second reset in mid-run
    wr(IDX_CFG, 32'h18);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    m_val = '{0, 0, 0};
    m_ctrl = 0;
    m_cfg = 0;
    for (int i = 11; i <= 18; i++) rdchk(6'(i), 32'hFFFF_FFFF);
    tally_and_finish;
  end

endmodule
`default_nettype wire
